// file: core/lmx_pkg.sv
// constants and types shared by the logic and move execution unit
package lmx_pkg;
  // operation codes presented on the command port
  typedef enum logic [4:0] {
    LMX_OP_AND_ACC_DIR,
    LMX_OP_OR_ACC_DIR,
    LMX_OP_XOR_ACC_DIR,
    LMX_OP_AND_DIR_ACC,
    LMX_OP_AND_DIR_IMM,
    LMX_OP_AND_REG_REG,
    LMX_OP_OR_REG_REG,
    LMX_OP_XOR_REG_REG,
    LMX_OP_MOV_REG_REG,
    LMX_OP_CLR_ACC,
    LMX_OP_CPL_ACC,
    LMX_OP_RLC_ACC,
    LMX_OP_RRC_ACC,
    LMX_OP_SWAP_ACC,
    LMX_OP_SRA_REG,
    LMX_OP_SRL_REG,
    LMX_OP_SLL_REG,
    LMX_OP_SIGN_EXTEND_MOVE,
    LMX_OP_ZERO_EXTEND_MOVE,
    LMX_OP_MOV_DRK_IMM0,
    LMX_OP_MOV_DRK_IMM1,
    LMX_OP_MOV_DATA_POINTER16_IMM,
    LMX_OP_MOV_DRK_DRK,
    LMX_OP_MOV_DIR_DIR,
    LMX_OP_MOV_WRJ_IND_DRK,
    LMX_OP_MOV_WRJ_DISP16,
    LMX_OP_MOV_WRJ_DISP24,
    LMX_OP_MOV_DIR16_DRK,
    LMX_OP_MOV_IND_DRK_RM,
    LMX_OP_MOV_ACC_DIR
  } lmx_op_type;

  // operand size of register shifts and extension moves
  localparam logic LMX_SIZE_BYTE = 1'b0;
  localparam logic LMX_SIZE_WORD = 1'b1;

  // encoding modes
  localparam logic LMX_MODE_BINARY = 1'b0;
  localparam logic LMX_MODE_SOURCE = 1'b1;

  // direct-address port register window
  localparam logic [7:0] LMX_PORT_ADDR_0 = 8'h80;
  localparam logic [7:0] LMX_PORT_ADDR_1 = 8'h90;
  localparam logic [7:0] LMX_PORT_ADDR_2 = 8'hA0;
  localparam logic [7:0] LMX_PORT_ADDR_3 = 8'hB0;

  // port penalties in states
  localparam logic [3:0] LMX_PORT_READ_PENALTY = 4'h1;
  localparam logic [3:0] LMX_PORT_WRITE_PENALTY = 4'h2;

  // reset values
  localparam logic [7:0] LMX_REGION_RESET = 8'h01;
  localparam logic [7:0] LMX_ACC_RESET = 8'h00;
  localparam logic [15:0] LMX_DATA_POINTER16_RESET = 16'h0000;
endpackage

// file: core/lmx_state_timer.sv
`timescale 1ns/1ps
// state count lookup and state counter for one instruction
module lmx_state_timer
  import lmx_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic start,
  input wire lmx_op_type op,
  input wire logic mode,
  input wire logic [3:0] penalty,
  output logic busy,
  output logic last
);
  logic [3:0] bin_states;
  logic [3:0] src_states;
  logic [3:0] total;
  logic [3:0] count;

  // listed state counts per encoding mode
  always_comb begin
    bin_states = 4'h1;
    src_states = 4'h1;
    case (op)
      LMX_OP_AND_DIR_ACC: begin
        bin_states = 4'h2;
        src_states = 4'h2;
      end
      LMX_OP_AND_DIR_IMM, LMX_OP_MOV_DIR_DIR: begin
        bin_states = 4'h3; // [RULE8] [RULE16]
        src_states = 4'h3;
      end
      LMX_OP_AND_REG_REG, LMX_OP_OR_REG_REG, LMX_OP_XOR_REG_REG, LMX_OP_MOV_REG_REG: begin
        bin_states = 4'h2; // [RULE9]
        src_states = 4'h1;
      end
      LMX_OP_SWAP_ACC: begin
        bin_states = 4'h2; // [RULE3]
        src_states = 4'h2;
      end
      LMX_OP_SRA_REG, LMX_OP_SRL_REG, LMX_OP_SLL_REG, LMX_OP_SIGN_EXTEND_MOVE, LMX_OP_ZERO_EXTEND_MOVE: begin
        bin_states = 4'h2; // [RULE6] [RULE7]
        src_states = 4'h1;
      end
      LMX_OP_MOV_DRK_IMM0, LMX_OP_MOV_DRK_IMM1, LMX_OP_MOV_WRJ_IND_DRK,
      LMX_OP_MOV_IND_DRK_RM: begin
        bin_states = 4'h5; // [RULE12] [RULE13] [RULE17] [RULE21]
        src_states = 4'h4;
      end
      LMX_OP_MOV_DATA_POINTER16_IMM: begin
        bin_states = 4'h2; // [RULE14]
        src_states = 4'h2;
      end
      LMX_OP_MOV_DRK_DRK: begin
        bin_states = 4'h3; // [RULE15]
        src_states = 4'h2;
      end
      LMX_OP_MOV_WRJ_DISP16, LMX_OP_MOV_DIR16_DRK: begin
        bin_states = 4'h7; // [RULE18] [RULE20]
        src_states = 4'h6;
      end
      LMX_OP_MOV_WRJ_DISP24: begin
        bin_states = 4'h8; // [RULE19]
        src_states = 4'h7;
      end
      default: begin
        bin_states = 4'h1; // [RULE4] [RULE5] [RULE24]
        src_states = 4'h1;
      end
    endcase
  end

  assign total = ((mode == LMX_MODE_SOURCE) ? src_states : bin_states) + penalty; // [RULE23]

  // counts remaining states; last marks the final state
  always_ff @(posedge clock) begin
    if (reset) begin
      count <= 4'h0;
      busy <= 1'b0;
      last <= 1'b0;
    end else if (start) begin
      count <= total - 4'h1;
      busy <= 1'b1;
      last <= (total == 4'h1);
    end else if (busy) begin
      count <= count - 4'h1;
      busy <= (count != 4'h0);
      last <= (count == 4'h1);
    end else begin
      last <= 1'b0;
    end
  end
endmodule

// file: core/lmx_shifter.sv
`timescale 1ns/1ps
// shift and extension datapath for byte and word register operands
module lmx_shifter
  import lmx_pkg::*;
(
  input wire lmx_op_type op,
  input wire logic size,
  input wire logic [15:0] operand,
  output logic [15:0] result
);
  logic [15:0] byte_res;
  logic [15:0] word_res;

  // byte-size results
  always_comb begin
    case (op)
      LMX_OP_SRA_REG: byte_res = {8'h00, operand[7], operand[7:1]}; // [RULE6]
      LMX_OP_SRL_REG: byte_res = {8'h00, 1'b0, operand[7:1]}; // [RULE7]
      LMX_OP_SLL_REG: byte_res = {8'h00, operand[6:0], 1'b0};
      LMX_OP_SIGN_EXTEND_MOVE: byte_res = {{8{operand[7]}}, operand[7:0]}; // [RULE10]
      LMX_OP_ZERO_EXTEND_MOVE: byte_res = {8'h00, operand[7:0]}; // [RULE11]
      default: byte_res = operand;
    endcase
  end

  // word-size results
  always_comb begin
    case (op)
      LMX_OP_SRA_REG: word_res = {operand[15], operand[15:1]}; // [RULE6]
      LMX_OP_SRL_REG: word_res = {1'b0, operand[15:1]}; // [RULE7]
      LMX_OP_SLL_REG: word_res = {operand[14:0], 1'b0};
      default: word_res = operand;
    endcase
  end

  assign result = (size == LMX_SIZE_WORD) ? word_res : byte_res;
endmodule

// file: core/lmx_exec.sv
`timescale 1ns/1ps
// logic and move instruction execution unit with state timing

// Notes on behaviour
// (RULE1) port register direct read adds one state
// (RULE2) logical write to port adds two states
// (RULE3) nibble swap, two states either mode
// (RULE4) rotate left through carry, one state
// (RULE5) rotate right through carry, one state
// (RULE6) arithmetic right shift keeps sign bit
// (RULE7) logical right shift inserts zero
// (RULE8) immediate logic to direct byte, three states
// (RULE9) byte register logic/move: two/one states
// (RULE10) sign-extending move replicates sign bit
// (RULE11) zero-extending move clears upper bits
// (RULE12) zero-extended immediate clears upper word
// (RULE13) one-extended immediate sets upper word
// (RULE14) data pointer immediate load, two states
// (RULE15) dword register move: three/two states
// (RULE16) direct to direct move, three states
// (RULE17) indirect dword pointer word load: five/four
// (RULE18) 16-bit displacement word load: seven/six
// (RULE19) 24-bit displacement word load: eight/seven
// (RULE20) dword store to direct16: seven/six
// (RULE21) byte store via dword pointer: five/four
// (RULE22) legacy external region from select byte
// (RULE23) encoding mode latched at reset
// (RULE24) clear and complement accumulator, one state
module lmx_exec
  import lmx_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic mode_strap,
  input wire logic start,
  input wire lmx_op_type op,
  input wire logic size,
  input wire logic [7:0] dir_addr,
  input wire logic [31:0] src_data,
  input wire logic [31:0] dst_data,
  input wire logic [15:0] imm_data,
  input wire logic [7:0] region_wdata,
  input wire logic region_we,
  output logic busy,
  output logic done,
  output logic [31:0] result,
  output logic [7:0] acc,
  output logic carry,
  output logic [15:0] data_pointer16,
  output logic [7:0] ext_region_select_byte,
  output logic mode
);
  logic in_reset;
  logic port_hit;
  logic reads_dir;
  logic writes_dir_logic;
  logic [3:0] penalty;
  logic [15:0] shift_res;
  logic [31:0] next_result;
  logic [7:0] next_acc;
  logic next_carry;
  logic timer_busy;
  logic timer_last;
  logic [7:0] dir_byte;
  logic strap_meta;
  logic strap_sync;

  // detects a direct address in the port register window
  assign port_hit = (dir_addr == LMX_PORT_ADDR_0) || (dir_addr == LMX_PORT_ADDR_1) ||
                    (dir_addr == LMX_PORT_ADDR_2) || (dir_addr == LMX_PORT_ADDR_3);
  assign reads_dir = (op == LMX_OP_AND_ACC_DIR) || (op == LMX_OP_OR_ACC_DIR) ||
                     (op == LMX_OP_XOR_ACC_DIR) || (op == LMX_OP_MOV_ACC_DIR);
  assign writes_dir_logic = (op == LMX_OP_AND_DIR_ACC) || (op == LMX_OP_AND_DIR_IMM);
  assign penalty = !port_hit ? 4'h0 :
                   writes_dir_logic ? LMX_PORT_WRITE_PENALTY : // [RULE2]
                   reads_dir ? LMX_PORT_READ_PENALTY : 4'h0; // [RULE1]
  assign dir_byte = src_data[7:0];

  lmx_state_timer u_timer (
    .clock(clock),
    .reset(reset),
    .start(start && !timer_busy),
    .op(op),
    .mode(mode),
    .penalty(penalty),
    .busy(timer_busy),
    .last(timer_last)
  );

  lmx_shifter u_shift (
    .op(op),
    .size(size),
    .operand(src_data[15:0]),
    .result(shift_res)
  );

  // result, accumulator and carry for each operation
  always_comb begin
    next_result = result;
    next_acc = acc;
    next_carry = carry;
    case (op)
      LMX_OP_AND_ACC_DIR: next_acc = acc & dir_byte;
      LMX_OP_OR_ACC_DIR: next_acc = acc | dir_byte;
      LMX_OP_XOR_ACC_DIR: next_acc = acc ^ dir_byte;
      LMX_OP_MOV_ACC_DIR: next_acc = dir_byte; // [RULE1]
      LMX_OP_AND_DIR_ACC: next_result = {24'h00_0000, dst_data[7:0] & acc}; // [RULE2]
      LMX_OP_AND_DIR_IMM: next_result = {24'h00_0000, dst_data[7:0] & imm_data[7:0]}; // [RULE8]
      LMX_OP_AND_REG_REG: next_result = {24'h00_0000, dst_data[7:0] & src_data[7:0]}; // [RULE9]
      LMX_OP_OR_REG_REG: next_result = {24'h00_0000, dst_data[7:0] | src_data[7:0]};
      LMX_OP_XOR_REG_REG: next_result = {24'h00_0000, dst_data[7:0] ^ src_data[7:0]};
      LMX_OP_MOV_REG_REG: next_result = {24'h00_0000, src_data[7:0]};
      LMX_OP_CLR_ACC: next_acc = 8'h00; // [RULE24]
      LMX_OP_CPL_ACC: next_acc = ~acc; // [RULE24]
      LMX_OP_RLC_ACC: begin
        next_acc = {acc[6:0], carry}; // [RULE4]
        next_carry = acc[7];
      end
      LMX_OP_RRC_ACC: begin
        next_acc = {carry, acc[7:1]}; // [RULE5]
        next_carry = acc[0];
      end
      LMX_OP_SWAP_ACC: next_acc = {acc[3:0], acc[7:4]}; // [RULE3]
      LMX_OP_SRA_REG, LMX_OP_SRL_REG, LMX_OP_SLL_REG: begin
        next_result = {16'h0000, shift_res}; // [RULE6] [RULE7]
        next_carry = (op == LMX_OP_SLL_REG) ?
                     ((size == LMX_SIZE_WORD) ? src_data[15] : src_data[7]) : src_data[0];
      end
      LMX_OP_SIGN_EXTEND_MOVE: next_result = {{16{shift_res[15]}}, shift_res}; // [RULE10]
      LMX_OP_ZERO_EXTEND_MOVE: next_result = {16'h0000, shift_res}; // [RULE11]
      LMX_OP_MOV_DRK_IMM0: next_result = {16'h0000, imm_data}; // [RULE12]
      LMX_OP_MOV_DRK_IMM1: next_result = {16'hFFFF, imm_data}; // [RULE13]
      LMX_OP_MOV_DRK_DRK, LMX_OP_MOV_DIR16_DRK: next_result = src_data; // [RULE15] [RULE20]
      LMX_OP_MOV_DIR_DIR: next_result = {24'h00_0000, src_data[7:0]}; // [RULE16]
      LMX_OP_MOV_WRJ_IND_DRK, LMX_OP_MOV_WRJ_DISP16, LMX_OP_MOV_WRJ_DISP24:
        next_result = {16'h0000, src_data[15:0]}; // [RULE17] [RULE18] [RULE19]
      LMX_OP_MOV_IND_DRK_RM: next_result = {24'h00_0000, src_data[7:0]}; // [RULE21]
      default: next_result = result;
    endcase
  end

  // two-stage synchroniser: the strap is a pin, so only the second stage reads the first stage
  always_ff @(posedge clock) begin
    strap_meta <= mode_strap;
    strap_sync <= strap_meta;
  end

  // encoding mode caught on the first edge after reset release
  always_ff @(posedge clock) begin
    if (reset) begin
      in_reset <= 1'b1;
      mode <= LMX_MODE_BINARY;
    end else begin
      in_reset <= 1'b0;
      if (in_reset) begin
        mode <= strap_sync; // [RULE23]
      end
    end
  end

  // architectural state updated when an instruction is accepted
  always_ff @(posedge clock) begin
    if (reset) begin
      result <= 32'h0000_0000;
      acc <= LMX_ACC_RESET;
      carry <= 1'b0;
    end else if (start && !timer_busy) begin
      result <= next_result;
      acc <= next_acc;
      carry <= next_carry;
    end
  end

  // data pointer and legacy external region select
  always_ff @(posedge clock) begin
    if (reset) begin
      data_pointer16 <= LMX_DATA_POINTER16_RESET;
      ext_region_select_byte <= LMX_REGION_RESET; // [RULE22]
    end else begin
      if (start && !timer_busy && op == LMX_OP_MOV_DATA_POINTER16_IMM) begin
        data_pointer16 <= imm_data; // [RULE14]
      end
      if (region_we) begin
        ext_region_select_byte <= region_wdata; // [RULE22]
      end
    end
  end

  // completion flags mirror the state timer
  always_ff @(posedge clock) begin
    if (reset) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      busy <= timer_busy;
      done <= timer_last;
    end
  end
endmodule

// file: dv/lmx_exec_sva.sv
// assertion checker bound to the logic and move execution unit
`timescale 1ns/1ps
module lmx_exec_sva
  import lmx_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic mode_strap,
  input wire logic start,
  input wire lmx_op_type op,
  input wire logic [7:0] dir_addr,
  input wire logic [7:0] region_wdata,
  input wire logic region_we,
  input wire logic busy,
  input wire logic done,
  input wire logic [7:0] acc,
  input wire logic carry,
  input wire logic [7:0] ext_region_select_byte,
  input wire logic mode
);
  // state count of one operation, b is the source mode, p a port access
  function automatic logic [3:0] st(lmx_op_type o, logic b, logic p);
    case (o)
      LMX_OP_AND_ACC_DIR, LMX_OP_OR_ACC_DIR, LMX_OP_XOR_ACC_DIR,
      LMX_OP_MOV_ACC_DIR: st = 4'h1 + {3'h0, p};
      LMX_OP_AND_DIR_ACC: st = 4'h2 + {2'h0, p, 1'b0};
      LMX_OP_AND_DIR_IMM: st = 4'h3 + {2'h0, p, 1'b0};
      LMX_OP_CLR_ACC, LMX_OP_CPL_ACC, LMX_OP_RLC_ACC, LMX_OP_RRC_ACC: st = 4'h1;
      LMX_OP_SWAP_ACC, LMX_OP_MOV_DATA_POINTER16_IMM: st = 4'h2;
      LMX_OP_MOV_DIR_DIR: st = 4'h3;
      LMX_OP_MOV_DRK_IMM0, LMX_OP_MOV_DRK_IMM1, LMX_OP_MOV_WRJ_IND_DRK,
      LMX_OP_MOV_IND_DRK_RM: st = 4'h5 - {3'h0, b};
      LMX_OP_MOV_DRK_DRK: st = 4'h3 - {3'h0, b};
      LMX_OP_MOV_WRJ_DISP16, LMX_OP_MOV_DIR16_DRK: st = 4'h7 - {3'h0, b};
      LMX_OP_MOV_WRJ_DISP24: st = 4'h8 - {3'h0, b};
      default: st = 4'h2 - {3'h0, b};
    endcase
  endfunction
  // accepted issue and port window decode
  wire take = start && !busy && !done;
  wire prt = dir_addr inside {LMX_PORT_ADDR_0, LMX_PORT_ADDR_1, LMX_PORT_ADDR_2, LMX_PORT_ADDR_3};
  logic [3:0] pend;
  // cycles left until the closing done pulse
  always_ff @(posedge clock) begin
    if (reset) pend <= 4'h0;
    else if (take) pend <= st(op, mode, prt) + 4'h1;
    else if (pend != 4'h0) pend <= pend - 4'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_rel;
    $past(reset) && !reset;
  endsequence
  sequence s_op(lmx_op_type o);
    take && op == o;
  endsequence
  AST_DONE_AT_COUNT:
    assert property (pend == 4'h1 |-> done) else $error("done missing at state count");
  AST_DONE_ONLY_AT_COUNT:
    assert property (done |-> pend == 4'h1) else $error("done outside state count");
  AST_TIMING_MODE:
    assert property (done |-> $past(pend) == 4'h2) else $error("done width wrong");
  AST_REGION_RESET: assert property (s_rel |-> ext_region_select_byte == 8'h01)
    else $error("region byte not at reset value");
  AST_REGION_WRITE:
    assert property (region_we |=> ext_region_select_byte == $past(region_wdata))
    else $error("region byte write lost");
  AST_MODE_LATCH: assert property (s_rel |=> mode == $past(mode_strap))
    else $error("mode not latched");
  AST_SWAP: assert property (s_op(LMX_OP_SWAP_ACC) |=> {acc[3:0], acc[7:4]} == $past(acc))
    else $error("nibble swap wrong");
  AST_RLC:
    assert property (s_op(LMX_OP_RLC_ACC) |=> {carry, acc} == {$past(acc), $past(carry)})
    else $error("rotate left wrong");
  AST_RRC:
    assert property (s_op(LMX_OP_RRC_ACC) |=> {acc, carry} == {$past(carry), $past(acc)})
    else $error("rotate right wrong");
  AST_CPL: assert property (s_op(LMX_OP_CPL_ACC) |=> acc == ~$past(acc))
    else $error("complement wrong");
  // busy stands for exactly the listed states, starting two cycles after the take
  AST_BUSY_SPAN:
    assert property (busy == (pend != 4'h0 && !$past(take)))
    else $error("busy span wrong");
endmodule
bind lmx_exec lmx_exec_sva u_sva (.clock(clock), .reset(reset), .mode_strap(mode_strap),
  .start(start), .op(op), .dir_addr(dir_addr), .region_wdata(region_wdata),
  .region_we(region_we), .busy(busy), .done(done), .acc(acc), .carry(carry),
  .ext_region_select_byte(ext_region_select_byte), .mode(mode));

// file: dv/tb_logic_move_instr_exec.sv
// self-checking bench for the logic and move execution unit
`timescale 1ns/1ps
module tb_logic_move_instr_exec
  import lmx_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic mode_strap = 1'b0;
  logic start = 1'b0;
  logic size = 1'b0;
  logic region_we = 1'b0;
  lmx_op_type op = LMX_OP_CLR_ACC;
  logic [7:0] dir_addr = 8'h00, region_wdata = 8'h00, acc, ext_region_select_byte, m_acc;
  logic [31:0] src_data = 32'h0, dst_data = 32'h0, result, s, d;
  logic [15:0] imm_data = 16'h0, data_pointer16;
  logic busy, done, carry, mode, m_c, z;
  lmx_op_type o;
  logic [7:0] da;
  int err_total = 0, total_checks = 0, cyc = 0;
  int seed = 32'ha08b_5d3a;
  lmx_exec DUT (.clock(clock), .reset(reset), .mode_strap(mode_strap), .start(start),
    .op(op), .size(size), .dir_addr(dir_addr), .src_data(src_data), .dst_data(dst_data),
    .imm_data(imm_data), .region_wdata(region_wdata), .region_we(region_we), .busy(busy),
    .done(done), .result(result), .acc(acc), .carry(carry), .data_pointer16(data_pointer16),
    .ext_region_select_byte(ext_region_select_byte), .mode(mode));
  // free running clock
  always #5 clock = ~clock;
  // cycle ceiling cuts a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // expected result, top bit set where the result port is meaningful
  function automatic logic [32:0] f(lmx_op_type o, logic z, logic [31:0] s, logic [31:0] d,
                                    logic [15:0] i, logic [7:0] a);
    f[32] = 1'b1;
    case (o)
      LMX_OP_AND_DIR_ACC: f[31:0] = {24'h0, d[7:0] & a};
      LMX_OP_AND_DIR_IMM: f[31:0] = {24'h0, d[7:0] & i[7:0]};
      LMX_OP_AND_REG_REG: f[31:0] = {24'h0, d[7:0] & s[7:0]};
      LMX_OP_OR_REG_REG: f[31:0] = {24'h0, d[7:0] | s[7:0]};
      LMX_OP_XOR_REG_REG: f[31:0] = {24'h0, d[7:0] ^ s[7:0]};
      LMX_OP_MOV_REG_REG, LMX_OP_MOV_DIR_DIR, LMX_OP_MOV_IND_DRK_RM,
      LMX_OP_ZERO_EXTEND_MOVE: f[31:0] = {24'h0, s[7:0]};
      LMX_OP_SRA_REG: f[31:0] = z ? {16'h0, s[15], s[15:1]} : {24'h0, s[7], s[7:1]};
      LMX_OP_SRL_REG: f[31:0] = z ? {17'h0, s[15:1]} : {25'h0, s[7:1]};
      LMX_OP_SLL_REG: f[31:0] = z ? {16'h0, s[14:0], 1'b0} : {24'h0, s[6:0], 1'b0};
      LMX_OP_SIGN_EXTEND_MOVE: f[31:0] = {{24{s[7]}}, s[7:0]};
      LMX_OP_MOV_DRK_IMM0: f[31:0] = {16'h0, i};
      LMX_OP_MOV_DRK_IMM1: f[31:0] = {16'hffff, i};
      LMX_OP_MOV_DRK_DRK, LMX_OP_MOV_DIR16_DRK: f[31:0] = s;
      LMX_OP_MOV_WRJ_IND_DRK, LMX_OP_MOV_WRJ_DISP16,
      LMX_OP_MOV_WRJ_DISP24: f[31:0] = {16'h0, s[15:0]};
      default: f = 33'h0;
    endcase
  endfunction
  // issue one instruction, wait for done, compare against the model
  task automatic run(input lmx_op_type o, input logic z, input logic [7:0] da,
                     input logic [31:0] s, input logic [31:0] d, input logic [15:0] i);
    logic [32:0] e;
    int n;
    e = f(o, z, s, d, i, m_acc);
    case (o)
      LMX_OP_AND_ACC_DIR: m_acc = m_acc & s[7:0];
      LMX_OP_OR_ACC_DIR: m_acc = m_acc | s[7:0];
      LMX_OP_XOR_ACC_DIR: m_acc = m_acc ^ s[7:0];
      LMX_OP_MOV_ACC_DIR: m_acc = s[7:0];
      LMX_OP_CLR_ACC: m_acc = 8'h00;
      LMX_OP_CPL_ACC: m_acc = ~m_acc;
      LMX_OP_RLC_ACC: {m_c, m_acc} = {m_acc, m_c};
      LMX_OP_RRC_ACC: {m_acc, m_c} = {m_c, m_acc};
      LMX_OP_SWAP_ACC: m_acc = {m_acc[3:0], m_acc[7:4]};
      LMX_OP_SRA_REG, LMX_OP_SRL_REG: m_c = s[0];
      LMX_OP_SLL_REG: m_c = z ? s[15] : s[7];
      default: ;
    endcase
    @(posedge clock);
    #1;
    start = 1'b1;
    op = o;
    size = z;
    dir_addr = da;
    src_data = s;
    dst_data = d;
    imm_data = i;
    @(posedge clock);
    #1;
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("done", 32'h1, {31'h0, done});
    if (o == LMX_OP_MOV_DATA_POINTER16_IMM) chk("data_pointer16", {16'h0, i}, {16'h0, data_pointer16});
    if (e[32]) chk("result", e[31:0], result);
    chk("acc", {24'h0, m_acc}, {24'h0, acc});
    chk("carry", {31'h0, m_c}, {31'h0, carry});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one pass per encoding mode, each behind its own reset
  initial begin
    for (int p = 0; p < 2; p++) begin
      mode_strap = p[0];
      reset = 1'b1;
      repeat (20) @(posedge clock);
      #1;
      reset = 1'b0;
      m_acc = LMX_ACC_RESET;
      m_c = 1'b0;
      @(posedge clock);
      #1;
      chk("mode", {31'h0, p[0]}, {31'h0, mode});
      chk("region", 32'h1, {24'h0, ext_region_select_byte});
      region_wdata = 8'($random(seed));
      region_we = 1'b1;
      @(posedge clock);
      #1;
      region_we = 1'b0;
      chk("region wr", {24'h0, region_wdata}, {24'h0, ext_region_select_byte});
      run(LMX_OP_MOV_ACC_DIR, 1'b0, 8'h80, 32'h96, 32'h0, 16'h0);
      run(LMX_OP_SWAP_ACC, 1'b0, 8'h10, 32'h0, 32'h0, 16'h0);
      run(LMX_OP_SIGN_EXTEND_MOVE, 1'b0, 8'h10, 32'h80, 32'h0, 16'h0);
      run(LMX_OP_SRA_REG, 1'b1, 8'h10, 32'h8001, 32'h0, 16'h0);
      run(LMX_OP_AND_DIR_IMM, 1'b0, 8'hb0, 32'h0, 32'hf0, 16'h3c);
      for (int r = 0; r < 60; r++) begin
        o = lmx_op_type'(r % 30);
        s = $random(seed);
        d = $random(seed);
        z = s[31] && o != LMX_OP_SIGN_EXTEND_MOVE && o != LMX_OP_ZERO_EXTEND_MOVE;
        da = r[0] ? {2'b10, s[5:4], 4'h0} : s[23:16];
        run(o, z, da, s, d, s[15:0]);
      end
      $display("mode %0d tests finished", p);
    end
    wrap_up();
  end
endmodule
